/* File: hw/spims_pkg.sv */
// Shared constants and types of the serial master/slave port.
package spims_pkg;

  // ==========================================================================
  // Register map: documented indices, byte address is four times the index.
  localparam logic [7:0]  SPIMS_IDX_DATA = 8'h3c;
  localparam logic [7:0]  SPIMS_IDX_CFG  = 8'h3d;
  localparam logic [11:0] SPIMS_A_DATA   = {2'h0, SPIMS_IDX_DATA, 2'h0};
  localparam logic [11:0] SPIMS_A_CFG    = {2'h0, SPIMS_IDX_CFG, 2'h0};
  localparam logic [11:0] SPIMS_A_PIN    = 12'h100;
  localparam logic [11:0] SPIMS_A_STAT   = 12'h104;
  localparam logic [11:0] SPIMS_A_MASK   = 12'h108;

  // ==========================================================================
  // Configuration register fields.
  localparam int SPIMS_CFG_SWAP = 7;
  localparam int SPIMS_CFG_LSB  = 6;
  localparam int SPIMS_CFG_MODE = 4;
  localparam int SPIMS_CFG_CPOL = 3;
  localparam int SPIMS_CFG_CPHA = 2;
  localparam int SPIMS_CFG_DIV  = 0;
  localparam logic [1:0] SPIMS_MODE_MST = 2'h1;
  localparam logic [1:0] SPIMS_MODE_SLV = 2'h2;

  // ==========================================================================
  // Clock divisors of the cpu clock for select codes 0 to 3.
  localparam logic [7:0] SPIMS_DIV0 = 8'h06;
  localparam logic [7:0] SPIMS_DIV1 = 8'h0c;
  localparam logic [7:0] SPIMS_DIV2 = 8'h30;
  localparam logic [7:0] SPIMS_DIV3 = 8'h60;
  localparam logic [3:0] SPIMS_LAST_EDGE = 4'hf;

  // ==========================================================================
  // Pin control register fields, status bits and pin indices.
  localparam int SPIMS_PIN_USE = 0;
  localparam int SPIMS_PIN_OE  = 4;
  localparam int SPIMS_PIN_OUT = 8;
  localparam int SPIMS_PIN_LVL = 12;
  localparam int SPIMS_P_SEL   = 0;
  localparam int SPIMS_P_CLK   = 1;
  localparam int SPIMS_P_MOSI  = 2;
  localparam int SPIMS_P_MISO  = 3;
  localparam int SPIMS_ST_RX   = 0;
  localparam int SPIMS_ST_TX   = 1;
  localparam int SPIMS_ST_BUSY = 2;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0]  SPIMS_RST_BYTE = 8'h00;
  localparam logic [11:0] SPIMS_RST_PIN  = 12'h000;
  localparam logic [1:0]  SPIMS_RST_ST   = 2'h0;

  typedef enum logic [1:0] {SPIMS_IDLE, SPIMS_LEAD, SPIMS_SHIFT} spims_state_e;

endpackage

/* File: hw/spims_sync.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module spims_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spims_sync_s;

  spims_sync_s r_r;
  spims_sync_s r_nxt;

  // ==========================================================================
  // Only the second stage reads the first.
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = async_i;
    r_nxt.s2 = r_r.s1;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r_r <= '0;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign sync_o = r_r.s2;

endmodule // spims_sync
`default_nettype wire

/* File: hw/spims_top.sv */
// Serial peripheral port, master or slave, with APB registers.
// Notes on behaviour
// - data read gives receive buffer, write loads holding
// - interrupt on byte received and holding empty
// - swap bit exchanges master-out and master-in pins
// - bit order: msb first, or lsb first
// - mode field: off, master, slave, reserved
// - polarity bit sets serial clock idle level
// - phase bit picks the sampling edge
// - master clock divides cpu clock by 6/12/48/96
// - core advances only while clock enable is high
// - four pins: clock, select, two data
// - select and data directions set automatically
// - serial logic owns select pin when enabled
// - clock/data pins serial only with use bit
`timescale 1ns/1ps
`default_nettype none
module spims_top
  import spims_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  input  wire logic        SELECT_PIN_I,
  output logic             SELECT_PIN_O,
  output logic             SELECT_PIN_OE_N_O,
  input  wire logic        CLOCK_PIN_I,
  output logic             CLOCK_PIN_O,
  output logic             CLOCK_PIN_OE_N_O,
  input  wire logic        MOSI_PORT_PIN_I,
  output logic             MOSI_PORT_PIN_O,
  output logic             MOSI_PORT_PIN_OE_N_O,
  input  wire logic        MISO_PORT_PIN_I,
  output logic             MISO_PORT_PIN_O,
  output logic             MISO_PORT_PIN_OE_N_O
);

  typedef struct packed {
    spims_state_e state;
    logic [7:0]   cfg;
    logic [7:0]   hold;
    logic         tx_full;
    logic [7:0]   tx_sh;
    logic [7:0]   rx_sh;
    logic [7:0]   rx_buf;
    logic [3:0]   edge_n;
    logic [6:0]   cnt;
    logic         sclk;
    logic         ss;
    logic         sclk_prev;
    logic         sel_prev;
    logic [11:0]  pin;
    logic [1:0]   st;
    logic [1:0]   mask;
    logic [31:0]  rdata;
  } spims_reg_s;

  spims_reg_s r_r;
  spims_reg_s r_nxt;
  logic [3:0] pin_s;
  logic       load_w;
  logic       done_w;

  // ==========================================================================
  // Helpers.

  // Half a serial clock period in cpu clocks, less one, for a select code.
  function automatic logic [6:0] half_f(input logic [1:0] sel);
    logic [7:0] d;
    d = SPIMS_DIV0;
    unique case (sel)
      2'h0: d = SPIMS_DIV0;
      2'h1: d = SPIMS_DIV1;
      2'h2: d = SPIMS_DIV2;
      2'h3: d = SPIMS_DIV3;
    endcase
    return d[7:1] - 7'h01;
  endfunction

  // Shift one bit in, in the configured order.
  function automatic logic [7:0] shf_f(input logic [7:0] v, input logic b, input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Register decode.
  function automatic logic hit_f(input logic [11:0] a);
    return a == SPIMS_A_DATA || a == SPIMS_A_CFG || a == SPIMS_A_PIN ||
           a == SPIMS_A_STAT || a == SPIMS_A_MASK;
  endfunction

  // ==========================================================================
  // Pin input synchronisers.
  spims_sync #(
    .W (4)
  ) u_sync (
    .clk_i    (CLK_I),
    .resetn_i (RESETN_I),
    .ce_i     (CE_I),
    .async_i  ({MISO_PORT_PIN_I, MOSI_PORT_PIN_I, CLOCK_PIN_I, SELECT_PIN_I}),
    .sync_o   (pin_s)
  );

  // ==========================================================================
  // Decoded configuration.
  logic [1:0] mode;
  logic       mst;
  logic       slv;
  logic       en;
  logic       lsb;
  logic       cpol;
  logic       cpha;
  logic       swap;
  logic       drv_mosi;
  logic       din;
  logic       dout;

  // Reserved mode code decodes as neither master nor slave.
  assign mode = r_r.cfg[SPIMS_CFG_MODE +: 2];
  assign mst  = mode == SPIMS_MODE_MST;
  assign slv  = mode == SPIMS_MODE_SLV;
  assign en   = mst | slv;
  assign lsb  = r_r.cfg[SPIMS_CFG_LSB];
  assign cpol = r_r.cfg[SPIMS_CFG_CPOL];
  assign cpha = r_r.cfg[SPIMS_CFG_CPHA];
  assign swap = r_r.cfg[SPIMS_CFG_SWAP];

  // The block drives the mosi port pin as master without swap, or as slave with swap.
  assign drv_mosi = mst ^ swap;
  assign din      = drv_mosi ? pin_s[SPIMS_P_MISO] : pin_s[SPIMS_P_MOSI];
  assign dout     = lsb ? r_r.tx_sh[0] : r_r.tx_sh[7];

  // ==========================================================================
  // Next-state logic: transfer engine and register writes.
  always_comb begin
    logic wr;
    logic rd_setup;
    logic sedge;
    logic tick;
    wr       = PSEL_I & PENABLE_I & PWRITE_I;
    rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    sedge    = 1'b0;
    tick     = 1'b0;
    load_w   = 1'b0;
    done_w   = 1'b0;
    r_nxt    = r_r;
    r_nxt.sclk_prev = pin_s[SPIMS_P_CLK];
    r_nxt.sel_prev  = pin_s[SPIMS_P_SEL];

    // Transfer sequencing; all shifting waits for a serial clock edge.
    unique case (r_r.state)
      SPIMS_IDLE: begin
        r_nxt.sclk   = cpol;
        r_nxt.ss     = 1'b1;
        r_nxt.edge_n = '0;
        if (mst && r_r.tx_full) begin
          load_w      = 1'b1;
          r_nxt.ss    = 1'b0;
          r_nxt.cnt   = half_f(r_r.cfg[SPIMS_CFG_DIV +: 2]);
          r_nxt.state = SPIMS_LEAD;
        end else if (slv && !pin_s[SPIMS_P_SEL] && r_r.sel_prev) begin
          load_w      = r_r.tx_full;
          r_nxt.state = SPIMS_SHIFT;
        end
      end
      SPIMS_LEAD: begin
        // Select is asserted a whole period before the first clock edge.
        if (r_r.cnt == '0) begin
          r_nxt.cnt   = half_f(r_r.cfg[SPIMS_CFG_DIV +: 2]);
          r_nxt.state = SPIMS_SHIFT;
        end else begin
          r_nxt.cnt = r_r.cnt - 7'h01;
        end
      end
      SPIMS_SHIFT: begin
        if (mst) begin
          tick = r_r.cnt == '0;
          if (tick) begin
            r_nxt.cnt  = half_f(r_r.cfg[SPIMS_CFG_DIV +: 2]);
            r_nxt.sclk = ~r_r.sclk;
          end else begin
            r_nxt.cnt = r_r.cnt - 7'h01;
          end
        end else begin
          tick = pin_s[SPIMS_P_CLK] != r_r.sclk_prev;
          if (pin_s[SPIMS_P_SEL]) begin
            r_nxt.state = SPIMS_IDLE;
          end
        end
        sedge = r_r.edge_n[0] == cpha;
        if (tick) begin
          if (sedge) begin
            r_nxt.rx_sh = shf_f(r_r.rx_sh, din, lsb);
          end else if (r_r.edge_n != '0) begin
            r_nxt.tx_sh = shf_f(r_r.tx_sh, 1'b0, lsb);
          end
          r_nxt.edge_n = r_r.edge_n + 4'h1;
          if (r_r.edge_n == SPIMS_LAST_EDGE) begin
            done_w       = 1'b1;
            r_nxt.rx_buf = sedge ? shf_f(r_r.rx_sh, din, lsb) : r_r.rx_sh;
            r_nxt.state  = SPIMS_IDLE;
          end
        end
      end
      default: begin
        r_nxt.state = SPIMS_IDLE;
      end
    endcase

    // Leaving master or slave mode abandons any transfer.
    if (!en) begin
      r_nxt.state = SPIMS_IDLE;
      r_nxt.ss    = 1'b1;
    end

    // Holding register moves to the shifter.
    if (load_w) begin
      r_nxt.tx_sh   = r_r.hold;
      r_nxt.tx_full = 1'b0;
    end

    // Software writes; status bits clear by writing one.
    if (wr) begin
      unique case (PADDR_I)
        SPIMS_A_DATA: begin
          r_nxt.hold    = PWDATA_I[7:0];
          r_nxt.tx_full = 1'b1;
        end
        SPIMS_A_CFG: begin
          r_nxt.cfg = PWDATA_I[7:0];
          // An idle clock takes a new polarity in the same cycle as the setting.
          if (r_r.state == SPIMS_IDLE) begin
            r_nxt.sclk = PWDATA_I[SPIMS_CFG_CPOL];
          end
        end
        SPIMS_A_PIN:  r_nxt.pin  = PWDATA_I[11:0];
        SPIMS_A_STAT: r_nxt.st   = r_r.st & ~PWDATA_I[1:0];
        SPIMS_A_MASK: r_nxt.mask = PWDATA_I[1:0];
        default: ;
      endcase
    end

    // Events set status after the clear, so a set in the same cycle wins.
    if (done_w) begin
      r_nxt.st[SPIMS_ST_RX] = 1'b1;
    end
    if (load_w) begin
      r_nxt.st[SPIMS_ST_TX] = 1'b1;
    end

    // Read data is captured in the setup cycle.
    if (rd_setup) begin
      r_nxt.rdata = '0;
      unique case (PADDR_I)
        SPIMS_A_DATA: r_nxt.rdata[7:0] = r_r.rx_buf;
        SPIMS_A_CFG:  r_nxt.rdata[7:0] = r_r.cfg;
        SPIMS_A_PIN:  r_nxt.rdata[15:0] = {pin_s, r_r.pin};
        SPIMS_A_STAT: r_nxt.rdata[2:0] = {r_r.state != SPIMS_IDLE, r_r.st};
        SPIMS_A_MASK: r_nxt.rdata[1:0] = r_r.mask;
        default: ;
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      r_r        <= '0;
      r_r.state  <= SPIMS_IDLE;
      r_r.cfg    <= SPIMS_RST_BYTE;
      r_r.hold   <= SPIMS_RST_BYTE;
      r_r.rx_buf <= SPIMS_RST_BYTE;
      r_r.pin    <= SPIMS_RST_PIN;
      r_r.st     <= SPIMS_RST_ST;
      r_r.mask   <= SPIMS_RST_ST;
      r_r.ss     <= 1'b1;
      r_r.sclk_prev <= 1'b0;
      r_r.sel_prev  <= 1'b1;
    end else if (CE_I) begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================================
  // APB answers: no wait states, error on an unmapped address.
  assign PRDATA_O  = r_r.rdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit_f(PADDR_I);
  assign IRQ_O     = |(r_r.st & r_r.mask);

  // ==========================================================================
  // Pin ownership: serial logic or general-purpose control.
  logic use_clk;
  logic use_mosi;
  logic use_miso;
  assign use_clk  = en & r_r.pin[SPIMS_PIN_USE + 0];
  assign use_mosi = en & r_r.pin[SPIMS_PIN_USE + 1];
  assign use_miso = en & r_r.pin[SPIMS_PIN_USE + 2];

  // Select is driven as master, an input as slave.
  assign SELECT_PIN_O      = en ? r_r.ss : r_r.pin[SPIMS_PIN_OUT + SPIMS_P_SEL];
  assign SELECT_PIN_OE_N_O = en ? ~mst : ~r_r.pin[SPIMS_PIN_OE + SPIMS_P_SEL];

  // Clock direction always follows the general-purpose enable bit.
  assign CLOCK_PIN_O      = use_clk ? r_r.sclk : r_r.pin[SPIMS_PIN_OUT + SPIMS_P_CLK];
  assign CLOCK_PIN_OE_N_O = ~r_r.pin[SPIMS_PIN_OE + SPIMS_P_CLK];

  // A slave data output is released while select is high.
  assign MOSI_PORT_PIN_O      = use_mosi ? dout : r_r.pin[SPIMS_PIN_OUT + SPIMS_P_MOSI];
  assign MOSI_PORT_PIN_OE_N_O = use_mosi ?
                                ~(drv_mosi & (mst | ~pin_s[SPIMS_P_SEL])) :
                                ~r_r.pin[SPIMS_PIN_OE + SPIMS_P_MOSI];
  assign MISO_PORT_PIN_O      = use_miso ? dout : r_r.pin[SPIMS_PIN_OUT + SPIMS_P_MISO];
  assign MISO_PORT_PIN_OE_N_O = use_miso ?
                                ~(~drv_mosi & (mst | ~pin_s[SPIMS_P_SEL])) :
                                ~r_r.pin[SPIMS_PIN_OE + SPIMS_P_MISO];

  // ==========================================================================
  // Assertions and cover points.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I || !CE_I);

  rd_data_a: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == SPIMS_A_DATA
    |=> PRDATA_O[7:0] == $past(r_r.rx_buf)) else $error("bad data read");
  wr_hold_a: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == SPIMS_A_DATA
    |=> r_r.tx_full && r_r.hold == $past(PWDATA_I[7:0])) else $error("bad hold");
  rx_event_a: assert property (done_w && r_r.mask[SPIMS_ST_RX]
    |=> r_r.st[SPIMS_ST_RX] && IRQ_O) else $error("rx event lost");
  tx_event_a: assert property (load_w |=> r_r.st[SPIMS_ST_TX])
    else $error("tx empty lost");
  swap_pins_a: assert property (mst && swap && use_mosi && use_miso
    |-> MOSI_PORT_PIN_OE_N_O && !MISO_PORT_PIN_OE_N_O) else $error("swap wrong");
  mode_off_a: assert property (!en |=> r_r.state == SPIMS_IDLE && r_r.ss)
    else $error("runs while off");
  clk_idle_a: assert property (r_r.state == SPIMS_IDLE && $past(r_r.state) == SPIMS_IDLE
    |-> r_r.sclk == cpol) else $error("idle level");
  half_per_a: assert property (mst && r_r.state == SPIMS_SHIFT && $changed(r_r.sclk)
    && r_r.edge_n != '0 && r_r.cfg[1:0] == 2'h0 && $stable(r_r.cfg)
    |-> ##1 $stable(r_r.sclk) ##1 $stable(r_r.sclk) ##1 $changed(r_r.sclk))
    else $error("divide by six");
  sel_own_a: assert property (mst |-> !SELECT_PIN_OE_N_O && SELECT_PIN_O == r_r.ss)
    else $error("select not owned");
  gpio_a: assert property (!en |-> CLOCK_PIN_O == r_r.pin[SPIMS_PIN_OUT + SPIMS_P_CLK]
    && MOSI_PORT_PIN_OE_N_O == !r_r.pin[SPIMS_PIN_OE + SPIMS_P_MOSI])
    else $error("gpio wrong");

  mst_done_c: cover property (mst && done_w);
  slv_done_c: cover property (slv && done_w);
  b2b_c:      cover property (done_w ##1 load_w);
  swap_c:     cover property (swap && done_w);

endmodule // spims_top
`default_nettype wire

/* File: verification/spims_peer_model.sv */
// Behavioural model of the external serial peripheral facing the port.
`timescale 1ns/1ps
`default_nettype none
module spims_peer_model (
  input  wire logic       sel_n_i,
  input  wire logic       sclk_i,
  input  wire logic       din_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output var logic        dout_o,
  output var logic  [7:0] rx_o
);
  int   edge_cnt;
  int   bit_cnt;
  logic sel_d  = 1'b1;
  logic sclk_d = 1'b0;

  // Returns bit k of the outgoing byte in the chosen order.
  function automatic logic pick(input logic [7:0] b, input int k);
    return lsb_i ? b[k] : b[7-k];
  endfunction

  // ==========================================================================
  // One process owns the line. A select change opens or closes a frame, and
  // a released line never keeps its last value. Inside a frame every clock
  // change is an edge; sampling and launching edges alternate.
  always @(sel_n_i or sclk_i) begin
    if (sel_n_i !== sel_d) begin
      edge_cnt = 0;
      bit_cnt  = 0;
      if (sel_n_i === 1'b0 && !cpha_i) begin
        dout_o  = pick(tx_i, 0);
        bit_cnt = 1;
      end else if (sel_n_i === 1'b1) begin
        dout_o = (dout_o === 1'b1) ? 1'b0 : 1'b1;
      end
    end else if (sclk_i !== sclk_d && sel_n_i === 1'b0) begin
      edge_cnt++;
      if ((edge_cnt % 2 == 1) != cpha_i) begin
        rx_o = lsb_i ? {din_i, rx_o[7:1]} : {rx_o[6:0], din_i};
      end else if (bit_cnt < 8) begin
        dout_o = pick(tx_i, bit_cnt);
        bit_cnt++;
      end
    end
    sel_d  = sel_n_i;
    sclk_d = sclk_i;
  end
endmodule // spims_peer_model
`default_nettype wire

/* File: verification/tb_spi_master_slave_port.sv */
// Self-checking testbench of the serial master/slave port.
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_port
  import spims_pkg::*;
;
  localparam int DIVS[4] = '{6, 12, 48, 96};
  logic        clk = 1'b0;
  logic        rst_n, ce, psel, pen, pwr, pready, pslverr, irq, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, r;
  logic        sel_o, sel_oe_n, clk_o, clk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic        tb_sel, tb_sclk, tb_mosi, slv, clk_prev, peer_dout;
  logic [7:0]  peer_tx, peer_rx, cur_cfg, got;
  int          edges = 0, run_len = 0, half_seen = 0, e0, mismatches = 0, checks_done = 0;
  wire         sel_line  = !sel_oe_n ? sel_o : tb_sel;
  wire         clk_line  = !clk_oe_n ? clk_o : tb_sclk;
  wire         mosi_line = !mosi_oe_n ? mosi_o : (slv ? tb_mosi : peer_dout);
  wire         miso_line = !miso_oe_n ? miso_o : (slv ? tb_mosi : peer_dout);

  always #2.5 clk = ~clk;

  spims_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .PADDR_I(paddr),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .SELECT_PIN_I(sel_line),
    .SELECT_PIN_O(sel_o), .SELECT_PIN_OE_N_O(sel_oe_n), .CLOCK_PIN_I(clk_line),
    .CLOCK_PIN_O(clk_o), .CLOCK_PIN_OE_N_O(clk_oe_n), .MOSI_PORT_PIN_I(mosi_line),
    .MOSI_PORT_PIN_O(mosi_o), .MOSI_PORT_PIN_OE_N_O(mosi_oe_n), .MISO_PORT_PIN_I(miso_line),
    .MISO_PORT_PIN_O(miso_o), .MISO_PORT_PIN_OE_N_O(miso_oe_n));

  spims_peer_model i_peer (.sel_n_i(sel_line), .sclk_i(clk_line),
    .din_i(cur_cfg[7] ? miso_line : mosi_line), .cpha_i(cur_cfg[2]), .lsb_i(cur_cfg[6]),
    .tx_i(peer_tx), .dout_o(peer_dout), .rx_o(peer_rx));

  // Counts serial clock changes and the spacing of the latest two.
  always @(posedge clk) begin
    clk_prev <= clk_line;
    if (clk_line !== clk_prev) begin
      edges     <= edges + 1;
      half_seen <= run_len + 1;
      run_len   <= 0;
    end else begin
      run_len <= run_len + 1;
    end
  end

  // ==========================================================================
  // Reporting, bus and transfer tasks.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
    checks_done++;
    if (got_v !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got_v);
      mismatches++;
    end
  endtask

  // One APB transfer; returns after one idle edge so register updates have landed.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pen    <= 1'b0;
    paddr  <= a;
    pwr    <= w;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    rd_err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    @(posedge clk);
  endtask

  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      apb(SPIMS_A_STAT, 1'b0, 32'h0);
      n++;
    end while (rd_data[SPIMS_ST_RX] !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic run_master(input logic [7:0] cfg, input logic [7:0] mo, input logic [7:0] pb);
    peer_tx = pb;
    cur_cfg = cfg;
    apb(SPIMS_A_CFG, 1'b1, {24'h0, cfg});
    apb(SPIMS_A_PIN, 1'b1, 32'h27);
    repeat (2) @(posedge clk);
    e0 = edges;
    chk("clock idle", {31'h0, cfg[3]}, {31'h0, clk_line});
    chk("pin dirs", {29'h0, 1'b0, cfg[7] ? 2'b10 : 2'b01},
        {29'h0, sel_oe_n, mosi_oe_n, miso_oe_n});
    apb(SPIMS_A_DATA, 1'b1, {24'h0, mo});
    wait_rx();
    chk("tx empty", 32'h1, {31'h0, rd_data[SPIMS_ST_TX]});
    apb(SPIMS_A_DATA, 1'b0, 32'h0);
    chk("rx byte", {24'h0, pb}, rd_data);
    chk("peer byte", {24'h0, mo}, {24'h0, peer_rx});
    chk("edge count", 32'd16, 32'(edges - e0));
    chk("half period", 32'(DIVS[cfg[1:0]] / 2), 32'(half_seen));
    apb(SPIMS_A_STAT, 1'b1, 32'h3);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0; ce = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    tb_sel = 1'b1; tb_sclk = 1'b0; tb_mosi = 1'b0; slv = 1'b0; cur_cfg = 8'h0; peer_tx = 8'h0;
    r = $urandom(32'ha7a8);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (DIVS[i]) begin
      apb(i[1] ? (i[0] ? SPIMS_A_MASK : SPIMS_A_STAT) : (i[0] ? SPIMS_A_PIN : SPIMS_A_CFG),
          1'b0, 32'h0);
      chk("reset value", 32'h0, rd_data & 32'h0fff);
    end
    apb(12'h200, 1'b1, 32'hffffffff);
    chk("unmapped error", 32'h1, {31'h0, rd_err});
    apb(12'h200, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rd_data);
    run_master(8'h10, 8'ha5, 8'h3c);
    run_master(8'hdf, 8'h81, 8'h7e);
    repeat (10) begin
      r = $urandom;
      run_master({r[7:6], 2'b01, r[3:0]}, r[15:8], r[23:16]);
    end
    // Interrupt raised, masked and cleared.
    apb(SPIMS_A_MASK, 1'b1, 32'h2);
    chk("irq idle", 32'h0, {31'h0, irq});
    apb(SPIMS_A_DATA, 1'b1, 32'h5a);
    repeat (4) @(posedge clk);
    chk("irq tx empty", 32'h1, {31'h0, irq});
    apb(SPIMS_A_MASK, 1'b1, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wait_rx();
    apb(SPIMS_A_MASK, 1'b1, 32'h1);
    chk("irq rx", 32'h1, {31'h0, irq});
    apb(SPIMS_A_STAT, 1'b1, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(SPIMS_A_STAT, 1'b0, 32'h0);
    chk("status w1c", 32'h2, rd_data & 32'h3);
    // Pin ownership in master mode with data use bits clear.
    apb(SPIMS_A_PIN, 1'b1, 32'h0450);
    chk("pin owners", 32'h0d, {27'h0, sel_oe_n, sel_o, clk_oe_n, mosi_oe_n, mosi_o});
    // Slave transfer with the bench as bus master, mode 0, msb first.
    slv = 1'b1;
    cur_cfg = 8'h20;
    apb(SPIMS_A_STAT, 1'b1, 32'h3);
    apb(SPIMS_A_PIN, 1'b1, 32'h07);
    apb(SPIMS_A_CFG, 1'b1, 32'h20);
    apb(SPIMS_A_DATA, 1'b1, 32'hc6);
    tb_sel <= 1'b0;
    repeat (8) @(posedge clk);
    chk("slave dirs", 32'h5, {29'h0, sel_oe_n, miso_oe_n, clk_oe_n});
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= r[i];
      repeat (8) @(posedge clk);
      got[i] = miso_line;
      tb_sclk <= 1'b1;
      repeat (8) @(posedge clk);
      tb_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    tb_sel <= 1'b1;
    wait_rx();
    apb(SPIMS_A_DATA, 1'b0, 32'h0);
    chk("slave rx", {24'h0, r[7:0]}, rd_data);
    chk("slave tx", 32'hc6, {24'h0, got});
    // Disabled and reserved modes: no clock, select and data back to general use.
    slv = 1'b0;
    apb(SPIMS_A_STAT, 1'b1, 32'h3);
    for (int m = 0; m < 4; m += 3) begin
      apb(SPIMS_A_CFG, 1'b1, 32'(m << 4));
      apb(SPIMS_A_PIN, 1'b1, 32'h37);
      chk("gpio pins", 32'h1, {29'h0, sel_oe_n, sel_o, mosi_oe_n});
      e0 = edges;
      apb(SPIMS_A_DATA, 1'b1, 32'h77);
      repeat (200) @(posedge clk);
      chk("no edges", 32'(e0), 32'(edges));
      apb(SPIMS_A_STAT, 1'b0, 32'h0);
      chk("no rx", 32'h0, {31'h0, rd_data[SPIMS_ST_RX]});
    end
    // A write made while the clock enable is low must not land.
    ce <= 1'b0;
    apb(SPIMS_A_MASK, 1'b1, 32'h3);
    ce <= 1'b1;
    apb(SPIMS_A_MASK, 1'b0, 32'h0);
    chk("frozen mask", 32'h1, rd_data & 32'h3);
    end_sim();
  end
endmodule // tb_spi_master_slave_port
`default_nettype wire
